// ---- hw/uic_pkg.sv ----
// Constants for the user interrupt controller: source layout, register map,
// command fields and timing. Assumes a single 100 MHz controller clock.
package uic_pkg;
	// Source selection word layout
	localparam int SRC_W = 24;
	localparam int SRC_IDX_W = 5;
	localparam int FAULT_POS = 0;
	localparam int EVT_LO_POS = 1;
	localparam int CNT_POS = 5;
	localparam int EVT_HI_POS = 11;
	localparam int TMR_POS = 15;
	localparam int MOD_POS = 19;
	localparam int N_EVT = 8;
	localparam int N_CNT = 6;
	localparam int N_TMR = 4;
	localparam int N_MOD = 5;
	localparam int N_PINS = N_EVT + N_CNT + N_MOD + 2;
	localparam int SYNC_STAGES = 3;

	// Register byte offsets
	localparam logic [7:0] OFS_DISABLE = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_FLUSH = 8'h08;
	localparam logic [7:0] OFS_LOST_CLR = 8'h0C;
	localparam logic [7:0] OFS_TSTART = 8'h10;
	localparam logic [7:0] OFS_ACTIVE = 8'h14;
	localparam logic [7:0] OFS_DONE = 8'h18;

	// Timed start command and routine-done status fields
	localparam int SP_W = 16;
	localparam int TS_SEL_LSB = 16;
	localparam int TS_SEL_W = 2;
	localparam int TS_EN_BIT = 31;
	localparam int DONE_FAULT_BIT = 31;
	localparam int DONE_BUSY_BIT = 30;

	// Mask reset value and the mask that keeps bit 0 enabled
	localparam logic [SRC_W-1:0] MASK_RST = 24'h00_0000;
	localparam logic [SRC_W-1:0] KEEP_BIT0 = 24'hFF_FFFE;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int MS_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// ---- hw/timed_channel.sv ----
// One periodic timed channel: counts millisecond ticks toward a setpoint.
// Assumes a one-cycle tick pulse and a load pulse from the controller.
`timescale 1ns/100ps
module timed_channel
	import uic_pkg::*;
#(
	parameter int SPW = SP_W
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// Control
	input wire logic i_tick,
	input wire logic i_load,
	input wire logic [SPW-1:0] i_setpoint,
	// Status
	output logic o_enable,
	output logic o_expire
);
	logic [SPW-1:0] sp_q;
	logic [SPW-1:0] cnt_q;
	logic [SPW-1:0] ticks_q;
	logic run_q;
	logic exp_q;
	wire at_end = (cnt_q == SPW'(sp_q - 1'b1));

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sp_q <= '0;
			cnt_q <= '0;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end else if (i_clk_en) begin
			exp_q <= 1'b0;
			if (i_load) begin
				// Restart from zero on any new setpoint
				sp_q <= i_setpoint; // R6
				cnt_q <= '0; // R6
				run_q <= |i_setpoint; // R4 R5
			end else if (run_q && i_tick) begin
				if (at_end) begin
					cnt_q <= '0;
					exp_q <= 1'b1; // R7
				end else begin
					cnt_q <= SPW'(cnt_q + 1'b1);
				end
			end
		end
	end

	assign o_enable = run_q;
	assign o_expire = exp_q;

	// Independent tick count since start, seen only by the check below
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ticks_q <= '0;
		end else if (i_clk_en) begin
			if (i_load || exp_q) begin
				ticks_q <= '0;
			end else if (run_q && i_tick) begin
				ticks_q <= SPW'(ticks_q + 1'b1);
			end
		end
	end

	chk_full_interval: assert property (@(posedge i_mclk) disable iff (i_sys_rst) // R7
		exp_q |-> (ticks_q == sp_q) && (sp_q != '0))
		else $error("timed channel expired before its full interval");
endmodule

// ---- hw/user_interrupt_control.sv ----
// User interrupt controller: fault handler launch, four timed channels,
// per-source mask, flush and lost-clear commands, priority dispatch.
// Assumes an AHB-Lite master, pins from outside the clock domain, and
// software that writes the routine-done register when a routine ends.
//
// Functional notes
// R1: Only user-class faults launch the fault handler
// R2: After fault handler completes, enter fault mode
// R3: Timed setpoint is unsigned 16-bit milliseconds
// R4: Zero setpoint stops channel, clears enable flag
// R5: Nonzero setpoint starts stopped channel, sets flag
// R6: New setpoint restarts running count from zero
// R7: Interrupt only after full setpoint interval
// R8: Timed start selects one of four channels
// R9: Timed start acts only when enabled; status mirrors
// R10: Module bits 19-23, timed channels bits 15-18
// R11: Events 1-4, counters 5-10, events 11-14
// R12: Bit 0 is fault handler, reserved for disable
// R13: Software ORs source weights into one word
// R14: Disabled sources wait until re-enabled
// R15: Flush discards selected pending requests
// R16: Clear resets selected interrupt-lost bits
// R17: Fixed priority, fault handler first, modules last
// R18: Higher request suspends lower running routine
// R19: Millisecond tick from prescaled system clock
// R20: Pending bit per source; recurrence sets lost
`timescale 1ns/100ps
module user_interrupt_control
	import uic_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	// Clock, reset, clock enable
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// Interrupt and fault pins
	input wire logic [N_EVT-1:0] i_event_input_irq,
	input wire logic [N_CNT-1:0] i_fast_counter_irq,
	input wire logic [N_MOD-1:0] i_module_irq,
	input wire logic i_user_fault,
	input wire logic i_other_fault,
	// Routine dispatch and status
	output logic o_dispatch,
	output logic [SRC_IDX_W-1:0] o_dispatch_vec,
	output logic [SRC_W-1:0] o_active,
	output logic o_fault_mode,
	output logic [N_TMR-1:0] o_timer_enable_flag,
	output logic o_status_out
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 2");
	end

	function automatic logic [SRC_IDX_W-1:0] first_set(input logic [SRC_W-1:0] v);
		logic [SRC_IDX_W-1:0] idx;
		idx = '0;
		for (int i = SRC_W - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = SRC_IDX_W'(i);
			end
		end
		return idx;
	endfunction

	// Pin synchronisers; an edge counts once stages two and three agree
	logic [N_PINS-1:0] pin_s1_q;
	logic [N_PINS-1:0] pin_s2_q;
	logic [N_PINS-1:0] pin_s3_q;
	logic [N_PINS-1:0] pin_filt_q;
	wire [N_PINS-1:0] pin_raw = {i_other_fault, i_user_fault, i_module_irq,
		i_fast_counter_irq, i_event_input_irq};
	wire [N_PINS-1:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);
	wire [N_PINS-1:0] pin_rise = pin_agree & pin_s2_q & ~pin_filt_q;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			pin_filt_q <= '0;
		end else if (i_clk_en) begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_filt_q <= (pin_agree & pin_s2_q) | (~pin_agree & pin_filt_q);
		end
	end

	wire [N_EVT-1:0] evt_rise = pin_rise[N_EVT-1:0];
	wire [N_CNT-1:0] cnt_rise = pin_rise[N_EVT+N_CNT-1:N_EVT];
	wire [N_MOD-1:0] mod_rise = pin_rise[N_PINS-3:N_EVT+N_CNT];
	wire user_rise = pin_rise[N_PINS-2];
	wire other_rise = pin_rise[N_PINS-1];

	// Millisecond prescaler
	logic [TICK_W-1:0] pre_q;
	logic tick_q;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pre_q <= '0;
			tick_q <= 1'b0;
		end else if (i_clk_en) begin
			tick_q <= (pre_q == TICK_W'(TICK_CYCLES - 1)); // R19
			pre_q <= (pre_q == TICK_W'(TICK_CYCLES - 1)) ? '0 : TICK_W'(pre_q + 1'b1);
		end
	end

	// AHB-Lite address phase capture; zero wait states, always OKAY
	logic wr_q;
	logic [7:0] waddr_q;
	logic [31:0] rdata_q;
	wire addr_take = i_hsel && i_htrans[1] && i_hready;
	wire [7:0] haddr_ofs = {i_haddr[7:2], 2'b00};
	wire addr_hit = (i_haddr[31:8] == 24'h00_0000);

	// Data phase write strobes
	wire wr_dis = wr_q && (waddr_q == OFS_DISABLE);
	wire wr_en = wr_q && (waddr_q == OFS_ENABLE);
	wire wr_flush = wr_q && (waddr_q == OFS_FLUSH);
	wire wr_clr = wr_q && (waddr_q == OFS_LOST_CLR);
	wire wr_ts = wr_q && (waddr_q == OFS_TSTART);
	wire wr_done = wr_q && (waddr_q == OFS_DONE);

	// One write carries every selected source at once
	wire [SRC_W-1:0] sel_word = i_hwdata[SRC_W-1:0]; // R13
	wire [SRC_W-1:0] flush_sel = wr_flush ? sel_word : '0;
	wire [SRC_W-1:0] clr_sel = wr_clr ? sel_word : '0;

	// Timed start command fields
	wire ts_go = wr_ts && i_hwdata[TS_EN_BIT]; // R9
	wire [TS_SEL_W-1:0] ts_sel = i_hwdata[TS_SEL_LSB+TS_SEL_W-1:TS_SEL_LSB]; // R8
	wire [SP_W-1:0] ts_sp = i_hwdata[SP_W-1:0]; // R3

	// Timed channels
	logic [N_TMR-1:0] tmr_exp;
	for (genvar c = 0; c < N_TMR; c++) begin : g_tmr
		timed_channel #(
			.SPW(SP_W)
		) u_chan (
			.i_mclk(i_mclk),
			.i_sys_rst(i_sys_rst),
			.i_clk_en(i_clk_en),
			.i_tick(tick_q),
			.i_load(ts_go && (ts_sel == TS_SEL_W'(c))), // R8
			.i_setpoint(ts_sp),
			.o_enable(o_timer_enable_flag[c]),
			.o_expire(tmr_exp[c])
		);
	end

	// Source events in priority order, bit 0 highest
	wire [SRC_W-1:0] hw_event = {mod_rise, tmr_exp, // R10
		evt_rise[N_EVT-1:4], cnt_rise, evt_rise[3:0], // R11
		user_rise}; // R1 R12

	// Pending, lost, mask and in-service state
	logic [SRC_W-1:0] pend_q;
	logic [SRC_W-1:0] lost_q;
	logic [SRC_W-1:0] mask_q;
	logic [SRC_W-1:0] act_q;
	logic fault_q;
	logic status_q;
	logic disp_q;
	logic [SRC_IDX_W-1:0] disp_vec_q;

	wire [SRC_W-1:0] cand = pend_q & ~mask_q; // R14
	wire [SRC_IDX_W-1:0] best = first_set(cand); // R17
	wire [SRC_IDX_W-1:0] cur = first_set(act_q);
	// Lower index is higher priority, so a smaller index suspends the running one
	wire preempt = (|cand) && (~|act_q || (best < cur)) && !fault_q; // R18
	wire [SRC_W-1:0] take_oh = preempt ? (SRC_W'(1) << best) : '0;
	wire done_any = wr_done && (|act_q);
	wire [SRC_W-1:0] done_oh = done_any ? (SRC_W'(1) << cur) : '0;
	wire fault_done = done_any && act_q[FAULT_POS];

	// New events win over a flush or clear in the same cycle
	wire [SRC_W-1:0] pend_d = (pend_q & ~flush_sel & ~take_oh) | hw_event; // R15 R20
	wire [SRC_W-1:0] lost_hit = hw_event & pend_q & ~take_oh;
	wire [SRC_W-1:0] lost_d = (lost_q & ~clr_sel) | lost_hit; // R16 R20
	wire [SRC_W-1:0] mask_set = wr_dis ? (sel_word & KEEP_BIT0) : '0; // R12
	wire [SRC_W-1:0] mask_clr = wr_en ? sel_word : '0;
	wire [SRC_W-1:0] mask_d = (mask_q | mask_set) & ~mask_clr & KEEP_BIT0; // R14
	wire [SRC_W-1:0] act_d = (act_q & ~done_oh) | take_oh; // R18
	// Non-user faults halt at once and never launch the handler
	wire fault_d = fault_q || fault_done || other_rise; // R1 R2

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pend_q <= '0;
			lost_q <= '0;
			mask_q <= MASK_RST;
			act_q <= '0;
			fault_q <= 1'b0;
		end else if (i_clk_en) begin
			pend_q <= pend_d;
			lost_q <= lost_d;
			mask_q <= mask_d;
			act_q <= act_d;
			fault_q <= fault_d;
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			disp_q <= 1'b0;
			disp_vec_q <= '0;
			status_q <= 1'b0;
		end else if (i_clk_en) begin
			disp_q <= preempt;
			if (preempt) begin
				disp_vec_q <= best;
			end
			if (wr_ts) begin
				status_q <= i_hwdata[TS_EN_BIT]; // R9
			end
		end
	end

	// Read mux; reads show live block state
	wire [31:0] done_rd = {fault_q, |act_q, 25'h000_0000, cur};
	wire [31:0] ts_rd = {status_q, 27'h000_0000, o_timer_enable_flag};
	wire [31:0] rd_mux =
		!addr_hit ? 32'h0000_0000 :
		(haddr_ofs == OFS_DISABLE) ? {8'h00, mask_q} :
		(haddr_ofs == OFS_ENABLE) ? {8'h00, mask_q} :
		(haddr_ofs == OFS_FLUSH) ? {8'h00, pend_q} :
		(haddr_ofs == OFS_LOST_CLR) ? {8'h00, lost_q} :
		(haddr_ofs == OFS_TSTART) ? ts_rd :
		(haddr_ofs == OFS_ACTIVE) ? {8'h00, act_q} :
		(haddr_ofs == OFS_DONE) ? done_rd : 32'h0000_0000;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_q <= 1'b0;
			waddr_q <= '0;
			rdata_q <= '0;
		end else if (i_clk_en) begin
			wr_q <= addr_take && i_hwrite && addr_hit;
			if (addr_take) begin
				waddr_q <= haddr_ofs;
			end
			if (addr_take && !i_hwrite) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = rdata_q;
	assign o_dispatch = disp_q;
	assign o_dispatch_vec = disp_vec_q;
	assign o_active = act_q;
	assign o_fault_mode = fault_q;
	assign o_status_out = status_q;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	sequence seq_fault_done;
		i_clk_en && fault_done;
	endsequence

	sequence seq_fault_held;
		o_fault_mode ##1 o_fault_mode;
	endsequence

	chk_user_fault_launch: assert property ( // R1
		i_clk_en && user_rise |=> pend_q[FAULT_POS] || act_q[FAULT_POS])
		else $error("user fault did not queue the handler");

	chk_other_fault_skip: assert property ( // R1
		i_clk_en && other_rise && !user_rise && !pend_q[FAULT_POS]
		|=> !pend_q[FAULT_POS] && o_fault_mode)
		else $error("non-user fault queued the handler");

	chk_fault_mode_entry: assert property ( // R2
		seq_fault_done |=> seq_fault_held)
		else $error("fault mode not entered after handler");

	chk_fault_halts: assert property ( // R2
		i_clk_en && o_fault_mode |=> !o_dispatch)
		else $error("dispatch while in fault mode");

	chk_zero_stops: assert property ( // R4
		i_clk_en && ts_go && (ts_sp == '0) |=> !o_timer_enable_flag[$past(ts_sel)])
		else $error("zero setpoint left channel enabled");

	chk_start_sets: assert property ( // R5
		i_clk_en && ts_go && (ts_sp != '0) |=> o_timer_enable_flag[$past(ts_sel)])
		else $error("nonzero setpoint did not enable channel");

	chk_status_mirror: assert property ( // R9
		i_clk_en && wr_ts |=> o_status_out == $past(i_hwdata[TS_EN_BIT]))
		else $error("status output differs from enable");

	chk_idle_no_load: assert property ( // R9
		i_clk_en && wr_ts && !i_hwdata[TS_EN_BIT]
		|=> o_timer_enable_flag == $past(o_timer_enable_flag))
		else $error("disabled timed start changed a channel");

	chk_mask_gates: assert property ( // R14
		preempt |-> !mask_q[best])
		else $error("masked source dispatched");

	chk_flush_drops: assert property ( // R15
		i_clk_en && wr_flush |=> (pend_q & $past(flush_sel) & ~$past(hw_event)) == '0)
		else $error("flushed request still pending");

	chk_lost_clear: assert property ( // R16
		i_clk_en && wr_clr |=> (lost_q & $past(clr_sel) & ~$past(lost_hit)) == '0)
		else $error("lost bit survived clear");

	chk_priority_order: assert property ( // R17
		i_clk_en && preempt |=> o_dispatch && (o_dispatch_vec == $past(first_set(cand))))
		else $error("dispatch not highest priority");

	chk_preempt_order: assert property ( // R18
		preempt && (|act_q) |-> best < cur)
		else $error("lower priority suspended a higher one");

	chk_tick_pulse: assert property ( // R19
		i_clk_en && tick_q |=> !tick_q)
		else $error("millisecond tick wider than one cycle");

	chk_lost_set: assert property ( // R20
		i_clk_en && (|lost_hit) |=> (lost_q & $past(lost_hit)) == $past(lost_hit))
		else $error("recurring event did not set lost");
endmodule

// ---- verification/user_interrupt_control_bench.sv ----
// Self-checking bench for the user interrupt controller.
// Assumes the package constants and a zero-wait AHB-Lite slave.
`timescale 1ns/100ps
module user_interrupt_control_bench;
	import uic_pkg::*;
	localparam int TK = 10;
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [N_PINS-1:0] pins = '0;
	logic [31:0] rd;
	wire logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic disp;
	logic [SRC_IDX_W-1:0] dvec;
	logic [SRC_W-1:0] active;
	logic fmode;
	logic [N_TMR-1:0] tflag;
	logic status;
	int fails = 0;
	int samples_checked = 0;
	int disp_cnt = 0;
	int n;
	int c;
	int exp_vec [19] = '{1, 2, 3, 4, 11, 12, 13, 14, 5, 6, 7, 8, 9, 10, 19, 20, 21, 22, 23};

	user_interrupt_control #(.TICK_CYCLES(TK)) i_user_interrupt_control (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
		.o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_event_input_irq(pins[7:0]), .i_fast_counter_irq(pins[13:8]),
		.i_module_irq(pins[18:14]), .i_user_fault(pins[19]), .i_other_fault(pins[20]),
		.o_dispatch(disp), .o_dispatch_vec(dvec), .o_active(active),
		.o_fault_mode(fmode), .o_timer_enable_flag(tflag), .o_status_out(status)
	);

	always #5 i_mclk = ~i_mclk;

	// Dispatch pulses last one cycle, so count them where they are settled
	always @(negedge i_mclk) begin
		if (disp === 1'b1) begin
			disp_cnt++;
		end
	end

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_flag(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		@(posedge i_mclk);
		while (hready !== 1'b1) @(posedge i_mclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge i_mclk);
		while (hready !== 1'b1) @(posedge i_mclk);
		rd = hrdata;
		// A write lands at this edge, so callers look once it has settled
		@(negedge i_mclk);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check_word(what, exp, rd);
	endtask

	task automatic done_rt();
		bus(1'b1, OFS_DONE, 32'h0000_0000);
	endtask

	task automatic tstart(input logic en, input logic [1:0] ch, input logic [15:0] sp);
		bus(1'b1, OFS_TSTART, {en, 13'h0000, ch, sp});
	endtask

	// Pins pass a synchroniser, so each level is held several cycles
	task automatic pulse(input logic [N_PINS-1:0] m);
		@(posedge i_mclk);
		pins <= m;
		repeat (6) @(posedge i_mclk);
		pins <= '0;
		repeat (6) @(posedge i_mclk);
	endtask

	task automatic wait_disp(output int k);
		k = 0;
		while (disp !== 1'b1 && k < 400) begin
			@(negedge i_mclk);
			k++;
		end
	endtask

	task automatic end_of_test();
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#200us;
		fails++;
		end_of_test();
	end

	initial begin
		repeat (2) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		@(negedge i_mclk);
		check_flag("hreadyout", 1'b1, hready);
		check_word("active rst", 32'h0000_0000, {8'h00, active});
		check_flag("fault rst", 1'b0, fmode);
		check_word("flags rst", 32'h0000_0000, {28'h000_0000, tflag});
		rd_chk("mask rst", OFS_DISABLE, 32'h0000_0000);
		rd_chk("unmapped", 8'h1C, 32'h0000_0000);
		check_flag("hresp", 1'b0, hresp);
		// Ordinary sources, one row each
		for (int r = 0; r < 19; r++) begin
			pulse(21'(1) << r);
			check_word("vec", 32'(exp_vec[r]), {27'h0, dvec});
			check_word("active", 32'h1 << exp_vec[r], {8'h00, active});
			done_rt();
			check_word("active done", 32'h0000_0000, {8'h00, active});
		end
		// Mask, lost and clear
		bus(1'b1, OFS_DISABLE, 32'h0000_0005);
		rd_chk("mask bit0", OFS_DISABLE, 32'h0000_0004);
		c = disp_cnt;
		pulse(21'h00_0002);
		pulse(21'h00_0002);
		check_word("masked", 32'(c), 32'(disp_cnt));
		rd_chk("pending", OFS_FLUSH, 32'h0000_0004);
		rd_chk("lost", OFS_LOST_CLR, 32'h0000_0004);
		bus(1'b1, OFS_LOST_CLR, 32'h0000_0004);
		rd_chk("lost clr", OFS_LOST_CLR, 32'h0000_0000);
		bus(1'b1, OFS_ENABLE, 32'h0000_0004);
		repeat (3) @(negedge i_mclk);
		check_word("unmask", 32'h0000_0002, {27'h0, dvec});
		done_rt();
		// Flush discards a masked request
		bus(1'b1, OFS_DISABLE, 32'h0000_0008);
		pulse(21'h00_0004);
		bus(1'b1, OFS_FLUSH, 32'h0000_0008);
		rd_chk("flushed", OFS_FLUSH, 32'h0000_0000);
		c = disp_cnt;
		bus(1'b1, OFS_ENABLE, 32'h0000_0008);
		repeat (10) @(posedge i_mclk);
		check_word("no flushed", 32'(c), 32'(disp_cnt));
		// Preemption by a higher source
		pulse(21'h00_4000);
		pulse(21'h00_0001);
		check_word("preempt", 32'h0008_0002, {8'h00, active});
		done_rt();
		check_word("resume", 32'h0008_0000, {8'h00, active});
		done_rt();
		// Two sources freed by one summed word
		bus(1'b1, OFS_DISABLE, 32'h0000_0024);
		pulse(21'h00_0102);
		bus(1'b1, OFS_ENABLE, 32'h0000_0024);
		repeat (3) @(negedge i_mclk);
		check_word("prio first", 32'h0000_0004, {8'h00, active});
		done_rt();
		repeat (3) @(negedge i_mclk);
		check_word("prio second", 32'h0000_0020, {8'h00, active});
		done_rt();
		// Restart of a running timed channel
		tstart(1'b1, 2'd1, 16'd3);
		repeat (15) @(posedge i_mclk);
		tstart(1'b1, 2'd1, 16'd5);
		wait_disp(n);
		check_flag("restart window", 1'b1, n >= 4 * TK && n <= 5 * TK + 8);
		check_word("timer vec", 32'd16, {27'h0, dvec});
		rd_chk("timing", OFS_TSTART, 32'h8000_0002);
		tstart(1'b1, 2'd1, 16'd0);
		rd_chk("stopped", OFS_TSTART, 32'h8000_0000);
		bus(1'b1, OFS_FLUSH, 32'h0001_0000);
		done_rt();
		tstart(1'b0, 2'd2, 16'd7);
		rd_chk("no start", OFS_TSTART, 32'h0000_0000);
		check_flag("status", 1'b0, status);
		// All four channels, masked, largest setpoint kept short
		bus(1'b1, OFS_DISABLE, 32'h0007_8000);
		for (int ch = 0; ch < 4; ch++) begin
			tstart(1'b1, 2'(ch), 16'd2);
		end
		check_word("four flags", 32'h0000_000F, {28'h000_0000, tflag});
		repeat (60) @(posedge i_mclk);
		rd_chk("timer pend", OFS_FLUSH, 32'h0007_8000);
		rd_chk("timer lost", OFS_LOST_CLR, 32'h0007_8000);
		for (int ch = 0; ch < 4; ch++) begin
			tstart(1'b1, 2'(ch), 16'd0);
		end
		bus(1'b1, OFS_FLUSH, 32'h0007_8000);
		bus(1'b1, OFS_LOST_CLR, 32'h0007_8000);
		rd_chk("pend clr", OFS_FLUSH, 32'h0000_0000);
		rd_chk("lost clr2", OFS_LOST_CLR, 32'h0000_0000);
		bus(1'b1, OFS_ENABLE, 32'h0007_8000);
		// Low clock enable freezes the pin stages, so the edge is never seen
		c = disp_cnt;
		@(posedge i_mclk);
		clk_en <= 1'b0;
		pulse(21'h00_0001);
		clk_en <= 1'b1;
		repeat (6) @(posedge i_mclk);
		check_word("frozen", 32'(c), 32'(disp_cnt));
		rd_chk("frozen pend", OFS_FLUSH, 32'h0000_0000);
		// User fault runs the handler, then halts
		pulse(21'h08_0000);
		check_word("handler", 32'h0000_0001, {8'h00, active});
		check_flag("no halt yet", 1'b0, fmode);
		done_rt();
		check_flag("halt", 1'b1, fmode);
		c = disp_cnt;
		pulse(21'h00_0001);
		check_word("halted", 32'(c), 32'(disp_cnt));
		// Second reset, then a fault that is not user-class
		@(posedge i_mclk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		@(negedge i_mclk);
		check_flag("fault cleared", 1'b0, fmode);
		c = disp_cnt;
		pulse(21'h10_0000);
		check_flag("other fault", 1'b1, fmode);
		check_word("no handler", 32'(c), 32'(disp_cnt));
		end_of_test();
	end
endmodule
